// ---- rtl/itrl_pkg.sv ----
// Purpose: shared constants for the interval timer readout latch
// Assumes: host I/O port accesses with 8-bit addresses and data
// Notes:   port map, control word fields, reset values, tick count

// =====================================================================
// package
package itrl_pkg;
    // i/o ports
    localparam logic [7:0] PORT_CNT0   = 8'h40;
    localparam logic [7:0] PORT_CNT2   = 8'h42;
    localparam logic [7:0] PORT_CMD    = 8'h43;
    localparam logic [7:0] PORT_SYSCTL = 8'h61;

    // control word fields
    localparam int         CW_SEL_LSB   = 6;
    localparam int         CW_FMT_LSB   = 4;
    localparam int         CW_MODE_LSB  = 1;
    localparam int         CW_BCD_BIT   = 0;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam int         RB_NCNT_BIT  = 5;
    localparam int         RB_NSTS_BIT  = 4;

    // system control port fields
    localparam int SC_GATE2_BIT = 0;
    localparam int SC_SPKEN_BIT = 1;
    localparam int SC_OUT2_BIT  = 5;

    // byte format of a counter
    typedef enum logic [1:0]
    {
        ITRL_FMT_LATCH = 2'b00,
        ITRL_FMT_LSB   = 2'b01,
        ITRL_FMT_MSB   = 2'b10,
        ITRL_FMT_BOTH  = 2'b11
    } itrl_fmt_e;

    // counting modes
    localparam logic [2:0] MODE_EOC     = 3'h0;
    localparam logic [2:0] MODE_ONESHOT = 3'h1;
    localparam logic [2:0] MODE_RATE    = 3'h2;
    localparam logic [2:0] MODE_SQUARE  = 3'h3;
    localparam logic [2:0] MODE_SWSTB   = 3'h4;
    localparam logic [2:0] MODE_HWSTB   = 3'h5;

    // values after reset
    localparam itrl_fmt_e  RST_FMT   = ITRL_FMT_BOTH;
    localparam logic [2:0] RST_MODE  = MODE_EOC;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // timer tick derived from the system clock
    localparam int CLK_PERIOD_NS = 40;
    localparam int TMR_PERIOD_NS = 838;
    localparam int TICK_CYC = (TMR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : itrl_pkg

// ---- rtl/itrl_count_core.sv ----
// Purpose: one live down counter with mode logic and output level
// Assumes: tick is a one-cycle pulse at the timer rate
// Notes:   counts in binary only; modes 6 and 7 alias 2 and 3

`timescale 1ns/1ps

// =====================================================================
// counter core
module itrl_count_core
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        tick,
    input  wire logic        gate,
    input  wire logic [2:0]  mode,
    input  wire logic        arm,
    input  wire logic        load,
    input  wire logic [15:0] load_val,
    output logic      [15:0] count,
    output logic             out_lvl,
    output logic             null_cnt
);
    logic [15:0] init_reg;
    logic        pend_reg;
    logic        run_reg;
    logic        gate_d_reg;
    logic [2:0]  md;
    logic        hw;
    logic        trig;

    // mode aliases and gate trigger
    assign md   = (mode[2:1] == 2'b11) ? {1'b0, mode[1:0]} : mode;
    assign hw   = (md == itrl_pkg::MODE_ONESHOT) || (md == itrl_pkg::MODE_HWSTB);
    assign trig = gate && !gate_d_reg;

    // gate edge history, sampled on timer ticks
    always_ff @(posedge clk)
    begin
        if (rst)
            gate_d_reg <= 1'b0;
        else if (ce && tick)
            gate_d_reg <= gate;
    end

    // load, reload and decrement
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            init_reg <= 16'h0000;
            count    <= 16'h0000;
            pend_reg <= 1'b0;
            run_reg  <= 1'b0;
            out_lvl  <= 1'b0;
            null_cnt <= 1'b0;
        end
        else if (ce)
        begin
            if (arm)
            begin
                out_lvl  <= (md != itrl_pkg::MODE_EOC);
                pend_reg <= 1'b0;
                run_reg  <= 1'b0;
            end
            else if (load)
            begin
                init_reg <= load_val;
                pend_reg <= 1'b1;
                null_cnt <= 1'b1;
                if (md == itrl_pkg::MODE_EOC)
                    out_lvl <= 1'b0;
            end
            else if (tick)
            begin
                if ((pend_reg && (!hw || trig)) || (hw && trig && run_reg))
                begin
                    count    <= init_reg;
                    pend_reg <= 1'b0;
                    null_cnt <= 1'b0;
                    run_reg  <= 1'b1;
                    if (md == itrl_pkg::MODE_ONESHOT)
                        out_lvl <= 1'b0;
                end
                else if (run_reg && (gate || hw))
                begin
                    case (md)
                        itrl_pkg::MODE_RATE:
                        begin
                            if (count == 16'h0001)
                            begin
                                count   <= init_reg;
                                out_lvl <= 1'b1;
                            end
                            else
                            begin
                                count   <= count - 16'h0001;
                                out_lvl <= (count != 16'h0002);
                            end
                        end
                        itrl_pkg::MODE_SQUARE:
                        begin
                            if (count <= 16'h0002)
                            begin
                                count   <= init_reg;
                                out_lvl <= !out_lvl;
                            end
                            else
                                count <= count - 16'h0002;
                        end
                        itrl_pkg::MODE_SWSTB, itrl_pkg::MODE_HWSTB:
                        begin
                            count   <= count - 16'h0001;
                            out_lvl <= (count != 16'h0001);
                        end
                        default:
                        begin
                            count <= count - 16'h0001;
                            if (count == 16'h0001)
                                out_lvl <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end
endmodule : itrl_count_core

// ---- rtl/itrl_readout_latch.sv ----
// Purpose: interval timer with count latch and read-back readout
// Assumes: one I/O access per cycle, strobes on the MCLK domain
// Notes:   counter 0 at 40h, counter 2 at 42h, commands at 43h

`timescale 1ns/1ps

// =====================================================================
// top
module itrl_readout_latch
#(
    parameter int TICK_DIV = itrl_pkg::TICK_CYC
)
(
    input  wire logic       MCLK,
    input  wire logic       SYS_RST,
    input  wire logic       CLK_EN,
    input  wire logic [7:0] IO_ADDR,
    input  wire logic       IO_WR,
    input  wire logic       IO_RD,
    input  wire logic [7:0] IO_WDATA,
    output logic      [7:0] IO_RDATA,
    output logic            TIMER0_OUT,
    output logic            SPEAKER_OUT
);
    localparam int NCH = 2;
    localparam int PW  = $clog2(TICK_DIV);

    itrl_pkg::itrl_fmt_e fmt_reg      [NCH];
    logic [2:0]          mode_reg     [NCH];
    logic [15:0]         lat_val_reg  [NCH];
    logic [7:0]          sts_val_reg  [NCH];
    logic [7:0]          wr_lo_reg    [NCH];
    logic [15:0]         load_val_reg [NCH];
    logic [15:0]         live         [NCH];
    logic [NCH-1:0]      bcd_reg;
    logic [NCH-1:0]      cnt_lat_reg;
    logic [NCH-1:0]      sts_lat_reg;
    logic [NCH-1:0]      rd_msb_reg;
    logic [NCH-1:0]      wr_msb_reg;
    logic [NCH-1:0]      load_reg;
    logic [NCH-1:0]      out_lvl;
    logic [NCH-1:0]      null_cnt;
    logic [NCH-1:0]      wr_cnt;
    logic [NCH-1:0]      rd_cnt;
    logic [NCH-1:0]      prog;
    logic [NCH-1:0]      lat_cmd;
    logic [NCH-1:0]      rb_cnt;
    logic [NCH-1:0]      rb_sts;
    logic [PW-1:0]       pre_reg;
    logic                tick_reg;
    logic                gate2_reg;
    logic                spk_en_reg;
    logic                cw_wr;

    // =================================================================
    // helpers

    // i/o port of a channel
    function automatic logic [7:0] chan_port(input int i);
        chan_port = (i == 0) ? itrl_pkg::PORT_CNT0 : itrl_pkg::PORT_CNT2;
    endfunction : chan_port

    // byte presented for the current read position
    function automatic logic [7:0] pick_byte(input itrl_pkg::itrl_fmt_e f,
                                             input logic msb,
                                             input logic [15:0] v);
        if (f == itrl_pkg::ITRL_FMT_MSB || (f == itrl_pkg::ITRL_FMT_BOTH && msb))
            pick_byte = v[15:8];
        else
            pick_byte = v[7:0];
    endfunction : pick_byte

    // true when this read completes the count
    function automatic logic last_byte(input itrl_pkg::itrl_fmt_e f,
                                       input logic msb);
        last_byte = (f != itrl_pkg::ITRL_FMT_BOTH) || msb;
    endfunction : last_byte

    // =================================================================
    // access decode
    assign cw_wr = CLK_EN && IO_WR && (IO_ADDR == itrl_pkg::PORT_CMD);

    // per-channel strobes from port accesses and command words
    always_comb
    begin
        wr_cnt  = '0;
        rd_cnt  = '0;
        prog    = '0;
        lat_cmd = '0;
        rb_cnt  = '0;
        rb_sts  = '0;
        for (int i = 0; i < NCH; i++)
        begin
            wr_cnt[i] = CLK_EN && IO_WR && (IO_ADDR == chan_port(i));
            rd_cnt[i] = CLK_EN && IO_RD && (IO_ADDR == chan_port(i));
            if (cw_wr && IO_WDATA[7:6] == 2'(2 * i))
            begin
                lat_cmd[i] = (IO_WDATA[5:4] == itrl_pkg::ITRL_FMT_LATCH);
                prog[i]    = (IO_WDATA[5:4] != itrl_pkg::ITRL_FMT_LATCH);
            end
            if (cw_wr && IO_WDATA[7:6] == itrl_pkg::SEL_READBACK && IO_WDATA[2 * i + 1])
            begin
                rb_cnt[i] = !IO_WDATA[itrl_pkg::RB_NCNT_BIT];
                rb_sts[i] = !IO_WDATA[itrl_pkg::RB_NSTS_BIT];
            end
        end
    end

    // =================================================================
    // timer tick prescaler
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            pre_reg  <= '0;
            tick_reg <= 1'b0;
        end
        else if (CLK_EN)
        begin
            tick_reg <= (pre_reg == PW'(TICK_DIV - 1));
            if (pre_reg == PW'(TICK_DIV - 1))
                pre_reg <= '0;
            else
                pre_reg <= pre_reg + 1'b1;
        end
    end

    // =================================================================
    // programming

    // control word: mode, format, bcd; latch commands leave them alone
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            fmt_reg  <= '{default: itrl_pkg::RST_FMT};
            mode_reg <= '{default: itrl_pkg::RST_MODE};
            bcd_reg  <= '0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (prog[i])
                begin
                    fmt_reg[i]  <= itrl_pkg::itrl_fmt_e'(IO_WDATA[5:4]);
                    mode_reg[i] <= IO_WDATA[3:1];
                    bcd_reg[i]  <= IO_WDATA[itrl_pkg::CW_BCD_BIT];
                end
            end
        end
    end

    // initial count writes in the programmed byte format
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            wr_msb_reg   <= '0;
            load_reg     <= '0;
            wr_lo_reg    <= '{default: 8'h00};
            load_val_reg <= '{default: 16'h0000};
        end
        else if (CLK_EN)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                load_reg[i] <= 1'b0;
                if (prog[i])
                    wr_msb_reg[i] <= 1'b0;
                else if (wr_cnt[i])
                begin
                    case (fmt_reg[i])
                        itrl_pkg::ITRL_FMT_LSB:
                        begin
                            load_reg[i]     <= 1'b1;
                            load_val_reg[i] <= {8'h00, IO_WDATA};
                        end
                        itrl_pkg::ITRL_FMT_MSB:
                        begin
                            load_reg[i]     <= 1'b1;
                            load_val_reg[i] <= {IO_WDATA, 8'h00};
                        end
                        default:
                        begin
                            wr_msb_reg[i] <= !wr_msb_reg[i];
                            if (!wr_msb_reg[i])
                                wr_lo_reg[i] <= IO_WDATA;
                            else
                            begin
                                load_reg[i]     <= 1'b1;
                                load_val_reg[i] <= {IO_WDATA, wr_lo_reg[i]};
                            end
                        end
                    endcase
                end
            end
        end
    end

    // system control port: gate and speaker enable
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            gate2_reg  <= 1'b0;
            spk_en_reg <= 1'b0;
        end
        else if (CLK_EN && IO_WR && IO_ADDR == itrl_pkg::PORT_SYSCTL)
        begin
            gate2_reg  <= IO_WDATA[itrl_pkg::SC_GATE2_BIT];
            spk_en_reg <= IO_WDATA[itrl_pkg::SC_SPKEN_BIT];
        end
    end

    // =================================================================
    // live counters; the latch only samples their count
    for (genvar g = 0; g < NCH; g++)
    begin : g_core
        itrl_count_core u_core
        (
            .clk      (MCLK),
            .rst      (SYS_RST),
            .ce       (CLK_EN),
            .tick     (tick_reg),
            .gate     ((g == 0) ? 1'b1 : gate2_reg),
            .mode     (mode_reg[g]),
            .arm      (prog[g]),
            .load     (load_reg[g]),
            .load_val (load_val_reg[g]),
            .count    (live[g]),
            .out_lvl  (out_lvl[g]),
            .null_cnt (null_cnt[g])
        );
    end

    // =================================================================
    // capture

    // count latch per channel, first capture wins
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            cnt_lat_reg <= '0;
            lat_val_reg <= '{default: 16'h0000};
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (prog[i])
                    cnt_lat_reg[i] <= 1'b0;
                else if ((lat_cmd[i] || rb_cnt[i]) && !cnt_lat_reg[i])
                begin
                    cnt_lat_reg[i] <= 1'b1;
                    lat_val_reg[i] <= live[i];
                end
                else if (rd_cnt[i] && !sts_lat_reg[i] && last_byte(fmt_reg[i], rd_msb_reg[i]))
                    cnt_lat_reg[i] <= 1'b0;
            end
        end
    end

    // status latch per channel, first capture wins
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            sts_lat_reg <= '0;
            sts_val_reg <= '{default: 8'h00};
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (prog[i])
                    sts_lat_reg[i] <= 1'b0;
                else if (rb_sts[i] && !sts_lat_reg[i])
                begin
                    sts_lat_reg[i] <= 1'b1;
                    sts_val_reg[i] <= {out_lvl[i], null_cnt[i], fmt_reg[i],
                                       mode_reg[i], bcd_reg[i]};
                end
                else if (rd_cnt[i])
                    sts_lat_reg[i] <= 1'b0;
            end
        end
    end

    // read byte pointer, low byte first
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            rd_msb_reg <= '0;
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (prog[i])
                    rd_msb_reg[i] <= 1'b0;
                else if (rd_cnt[i] && !sts_lat_reg[i] && fmt_reg[i] == itrl_pkg::ITRL_FMT_BOTH)
                    rd_msb_reg[i] <= !rd_msb_reg[i];
            end
        end
    end

    // =================================================================
    // read data: status first, then latched count, else live count
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            IO_RDATA <= itrl_pkg::RST_RDATA;
        else if (CLK_EN && IO_RD)
        begin
            if (IO_ADDR == itrl_pkg::PORT_SYSCTL)
                IO_RDATA <= {2'b00, out_lvl[1], 3'b000, spk_en_reg, gate2_reg};
            else
                IO_RDATA <= 8'h00;
            for (int i = 0; i < NCH; i++)
            begin
                if (rd_cnt[i] && sts_lat_reg[i])
                    IO_RDATA <= sts_val_reg[i];
                else if (rd_cnt[i])
                    IO_RDATA <= pick_byte(fmt_reg[i], rd_msb_reg[i],
                                          cnt_lat_reg[i] ? lat_val_reg[i] : live[i]);
            end
        end
    end

    // timer outputs
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            TIMER0_OUT  <= 1'b0;
            SPEAKER_OUT <= 1'b0;
        end
        else if (CLK_EN)
        begin
            TIMER0_OUT  <= out_lvl[0];
            SPEAKER_OUT <= out_lvl[1] && spk_en_reg;
        end
    end

    // =================================================================
    // checks
    latch_capture_a : assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        lat_cmd[0] && !cnt_lat_reg[0] |=> cnt_lat_reg[0] && lat_val_reg[0] == $past(live[0]))
        else $error("count latch did not capture the live count");

    latch_ignore_a : assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        lat_cmd[0] && cnt_lat_reg[0] |=> $stable(lat_val_reg[0]) && cnt_lat_reg[0])
        else $error("second latch overwrote the held count");

    latch_release_a : assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        rd_cnt[1] && cnt_lat_reg[1] && !sts_lat_reg[1] && last_byte(fmt_reg[1], rd_msb_reg[1])
        |=> !cnt_lat_reg[1])
        else $error("latch not released after full read");

    reprog_unlatch_a : assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        prog[0] |=> !cnt_lat_reg[0] && !sts_lat_reg[0] && !rd_msb_reg[0])
        else $error("reprogramming left a latch held");

    mode_kept_a : assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        lat_cmd[0] |=> $stable(mode_reg[0]) && $stable(fmt_reg[0]))
        else $error("latch command changed mode or format");

    latched_data_a : assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        rd_cnt[0] && cnt_lat_reg[0] && !sts_lat_reg[0] && fmt_reg[0] == itrl_pkg::ITRL_FMT_LSB
        |=> IO_RDATA == $past(lat_val_reg[0][7:0]))
        else $error("latched low byte not returned");

    status_first_a : assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        rd_cnt[1] && sts_lat_reg[1] && cnt_lat_reg[1]
        |=> IO_RDATA == $past(sts_val_reg[1]) && !sts_lat_reg[1] && cnt_lat_reg[1])
        else $error("status not returned ahead of count");

    other_held_a : assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        rd_cnt[0] && cnt_lat_reg[1] |=> cnt_lat_reg[1] && $stable(lat_val_reg[1]))
        else $error("read of one counter released another");

    status_ignore_a : assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        rb_sts[0] && sts_lat_reg[0] |=> $stable(sts_val_reg[0]))
        else $error("repeated status capture overwrote status");

    readback_both_a : assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        rb_cnt[1] && rb_sts[1] && !cnt_lat_reg[1] && !sts_lat_reg[1]
        |=> cnt_lat_reg[1] && sts_lat_reg[1] && sts_val_reg[1][7] == $past(out_lvl[1]))
        else $error("read-back did not capture count and status");

    ptr_toggle_a : assert property (
        @(posedge MCLK) disable iff (SYS_RST)
        rd_cnt[0] && !sts_lat_reg[0] && fmt_reg[0] == itrl_pkg::ITRL_FMT_BOTH
        |=> rd_msb_reg[0] != $past(rd_msb_reg[0]))
        else $error("read byte pointer did not advance");
endmodule : itrl_readout_latch

// ---- verification/itrl_tb.sv ----
// Purpose: self-checking bench for the interval timer readout latch
// Assumes: counter 2 halted by its gate holds a known count
// Notes:   TICK_DIV shortened to 2; ctr0 count large so its output stays high

`timescale 1ns/1ps

// =====================================================================
// bench top
module testbench;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  io_addr = 8'h00;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic [7:0]  io_rdata;
    logic        timer0_out;
    logic        spk;
    logic        clk_en = 1'b1;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [15:0] v;
    int          errors = 0;
    int          n_compared = 0;

    itrl_readout_latch #(.TICK_DIV(2)) u_dut
    (
        .MCLK(mclk), .SYS_RST(sys_rst), .CLK_EN(clk_en), .IO_ADDR(io_addr),
        .IO_WR(io_wr), .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata),
        .TIMER0_OUT(timer0_out), .SPEAKER_OUT(spk)
    );

    // clock, 40 ns period
    always #20 mclk = ~mclk;

    // compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one port write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge mclk);
        io_wr    <= 1'b0;
    endtask : wr

    // one port read, data sampled after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge mclk);
        io_rd   <= 1'b0;
        #1 d = io_rdata;
    endtask : rd

    // program both counters, ctr2 halted
    task automatic t_setup;
        rd(8'h41, lo);
        chk("unmapped", 8'h00, lo);
        wr(8'h61, 8'h00);
        wr(8'h43, 8'h34);
        wr(8'h40, 8'h00);
        wr(8'h40, 8'hf0);
        wr(8'h43, 8'hb0);
        wr(8'h42, 8'h34);
        wr(8'h42, 8'h12);
        repeat (10) @(posedge mclk);
        rd(8'h42, lo);
        rd(8'h42, hi);
        chk("live lo", 8'h34, lo);
        chk("live hi", 8'h12, hi);
        chk("out0", 8'h01, {7'h00, timer0_out});
    endtask : t_setup

    // latch, run, relatch, interleaved read
    task automatic t_latch;
        wr(8'h43, 8'h80);
        wr(8'h61, 8'h01);
        repeat (20) @(posedge mclk);
        wr(8'h43, 8'h80);
        wr(8'h61, 8'h00);
        rd(8'h42, lo);
        rd(8'h40, hi);
        rd(8'h42, hi);
        chk("latch lo", 8'h34, lo);
        chk("latch hi", 8'h12, hi);
        rd(8'h42, v[7:0]);
        rd(8'h42, v[15:8]);
        chk("moved", 8'h01, {7'h00, v < 16'h1234});
    endtask : t_latch

    // read-back: count then status, multi-select
    task automatic t_readback;
        wr(8'h43, 8'hd8);
        wr(8'h43, 8'he8);
        wr(8'h43, 8'he8);
        rd(8'h42, lo);
        chk("status", 8'h30, lo);
        rd(8'h42, lo);
        rd(8'h42, hi);
        chk("rb lo", v[7:0], lo);
        chk("rb hi", v[15:8], hi);
        wr(8'h43, 8'hca);
        rd(8'h42, lo);
        chk("status2", 8'h30, lo);
        rd(8'h40, lo);
        chk("status0", 8'hb4, lo);
    endtask : t_readback

    // reprogramming drops a held latch
    task automatic t_reprog;
        wr(8'h43, 8'h80);
        wr(8'h43, 8'hb0);
        wr(8'h42, 8'h00);
        wr(8'h42, 8'h02);
        repeat (10) @(posedge mclk);
        rd(8'h42, lo);
        rd(8'h42, hi);
        chk("new lo", 8'h00, lo);
        chk("new hi", 8'h02, hi);
        wr(8'h42, 8'h04);
        wr(8'h42, 8'h00);
        wr(8'h61, 8'h02);
        repeat (6) @(posedge mclk);
        rd(8'h61, lo);
        chk("sysctl idle", 8'h02, lo);
        chk("speaker idle", 8'h00, {7'h00, spk});
        wr(8'h61, 8'h03);
        repeat (20) @(posedge mclk);
        rd(8'h61, lo);
        chk("sysctl out2", 8'h23, lo);
        chk("speaker on", 8'h01, {7'h00, spk});
    endtask : t_reprog

    // counter 0: low-byte latch, repeats ignored, clock enable freeze
    task automatic t_ctr0;
        wr(8'h43, 8'h14);
        wr(8'h40, 8'hf0);
        repeat (4) @(posedge mclk);
        wr(8'h43, 8'h00);
        repeat (10) @(posedge mclk);
        wr(8'h43, 8'h00);
        rd(8'h40, lo);
        rd(8'h40, hi);
        chk("ctr0 hold", 8'h01, {7'h00, (lo - hi) > 8'h04});
        wr(8'h43, 8'he2);
        wr(8'h43, 8'he2);
        rd(8'h40, lo);
        chk("status ctr0", 8'h94, lo);
        @(posedge mclk);
        clk_en <= 1'b0;
        wr(8'h43, 8'he2);
        rd(8'h40, lo);
        chk("frozen data", 8'h94, lo);
        @(posedge mclk);
        clk_en <= 1'b1;
        rd(8'h40, lo);
        chk("frozen cmd", 8'h01, {7'h00, lo != 8'h94});
    endtask : t_ctr0

    // verdict and end of run
    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // main sequence
    initial
    begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        t_setup();
        t_latch();
        t_readback();
        t_reprog();
        t_ctr0();
        stop_test();
    end

    // watchdog
    initial
    begin
        #(40 * 4000);
        errors++;
        stop_test();
    end
endmodule : testbench
